// *** common/lvsi_pkg.sv ***
// Package for the low-voltage sub-idle gating block
package lvsi_pkg;
	// Register byte offsets
	localparam logic [7:0] LVSI_CTRL_OFS = 8'h00;
	localparam logic [7:0] LVSI_CLKSEL_OFS = 8'h04;
	localparam logic [7:0] LVSI_STAT_OFS = 8'h08;
	localparam logic [7:0] LVSI_GATE_OFS = 8'h0C;
	// Control register fields
	localparam int CTRL_ENTER_BIT = 0;
	localparam int CTRL_PLL_EN_BIT = 1;
	localparam int CTRL_MAIN_OSC_BIT = 2;
	localparam int CTRL_ADC_BIT = 3;
	localparam int CTRL_DAC_BIT = 4;
	localparam logic [4:0] CTRL_RESET = 5'h16;
	// Clock select fields
	localparam int CLKSEL_TMM_POS = 0;
	localparam int CLKSEL_WDT_POS = 2;
	localparam int CLKSEL_WATCH_POS = 4;
	localparam logic [5:0] CLKSEL_RESET = 6'h00;
	// Count clock sources
	localparam logic [1:0] SRC_MAIN = 2'h0;
	localparam logic [1:0] SRC_INTOSC_DIV8 = 2'h1;
	localparam logic [1:0] SRC_SUBCLK = 2'h2;
	// Gate vector bit positions (1 = unit clock runs)
	localparam int G_PLL = 0;
	localparam int G_CPU = 1;
	localparam int G_DMA = 2;
	localparam int G_TMP = 3;
	localparam int G_TMQ = 4;
	localparam int G_TMM = 5;
	localparam int G_WDT = 6;
	localparam int G_WATCH = 7;
	localparam int G_CSI = 8;
	localparam int G_IIC = 9;
	localparam int G_UARTA = 10;
	localparam int G_UARTC = 11;
	localparam int G_ADC = 12;
	localparam int G_DAC = 13;
	localparam int G_RTO = 14;
	localparam int G_CRC = 15;
	localparam int G_LVD = 16;
	localparam int G_KEY = 17;
	localparam int G_INTC = 18;
	localparam int GATE_W = 19;
	localparam logic [GATE_W-1:0] GATE_ALL = 19'h7FFFF;
	// Status error codes
	localparam logic [1:0] ERR_NONE = 2'h0;
	localparam logic [1:0] ERR_MAIN_RUN = 2'h1;
	localparam logic [1:0] ERR_PLL_ON = 2'h2;
	localparam logic [1:0] ERR_DAC_ON = 2'h3;
	localparam int RTO_W = 8;
	localparam int PORT_W = 16;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;
	typedef enum logic [1:0] {LVSI_RUN, LVSI_SLEEP, LVSI_WAKE} lvsi_state_t;
endpackage : lvsi_pkg

// *** rtl/lvsi_axil.sv ***
// AXI4-Lite slave front end for the gating block
`timescale 1ns/10ps
`default_nettype none
module lvsi_axil
	import lvsi_pkg::*;
(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Write channels
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// Read channels
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Register side
	output logic wr_pulse,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	output logic [7:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_hit,
	input wire logic wr_hit
);
	logic aw_have_q, w_have_q;
	logic [7:0] aw_q;
	logic [31:0] w_q;
	logic [3:0] s_q;

	// Readies drop with clk_en so no item is taken while frozen
	assign awready = clk_en && !aw_have_q && !bvalid;
	assign wready = clk_en && !w_have_q && !bvalid;
	assign arready = clk_en && !rvalid;
	assign wr_pulse = clk_en && aw_have_q && w_have_q && !bvalid;
	assign wr_addr = aw_q;
	assign wr_data = w_q;
	assign wr_strb = s_q;
	assign rd_addr = araddr;

	// Capture address and data in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_q <= 8'h00;
			w_q <= 32'h00000000;
			s_q <= 4'h0;
		end else if (clk_en) begin
			if (awvalid && awready) begin
				aw_have_q <= 1'b1;
				aw_q <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_q <= 1'b1;
				w_q <= wdata;
				s_q <= wstrb;
			end
			if (wr_pulse) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp <= AXI_OKAY;
		end else if (clk_en) begin
			if (wr_pulse) begin
				bvalid <= 1'b1;
				bresp <= wr_hit ? AXI_OKAY : AXI_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h00000000;
			rresp <= AXI_OKAY;
		end else if (clk_en) begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= rd_hit ? rd_data : 32'h00000000;
				rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
			end else if (rready) begin
				rvalid <= 1'b0;
			end
		end
	end
endmodule : lvsi_axil
`default_nettype wire

// *** rtl/lvsi_gating.sv ***
// Low-voltage sub-idle gating controller with register file
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module lvsi_gating
	import lvsi_pkg::*;
(
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Wake sources
	input wire logic wake_req,
	// Unit outputs to hold
	input wire logic [RTO_W-1:0] rto_live,
	input wire logic [PORT_W-1:0] port_live,
	output logic [RTO_W-1:0] rto_pins,
	output logic [PORT_W-1:0] port_pins,
	// Unit clock enables and status
	output logic [GATE_W-1:0] unit_run,
	output logic cpu_regs_hold,
	output logic in_sleep
);
	lvsi_state_t state_q;
	logic [4:0] ctrl_q;
	logic [5:0] clksel_q;
	logic [1:0] err_q;
	logic [GATE_W-1:0] gate_d;
	logic [RTO_W-1:0] rto_q;
	logic [PORT_W-1:0] port_q;
	logic wr_pulse;
	logic [7:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic rd_hit, wr_hit;
	logic enter_req;

	// Source allowed in sleep for timer M / watchdog
	function automatic logic slow_src_ok(input logic [1:0] src);
		return (src == SRC_INTOSC_DIV8) || (src == SRC_SUBCLK);
	endfunction : slow_src_ok

	function automatic logic hit(input logic [7:0] a);
		return a == LVSI_CTRL_OFS || a == LVSI_CLKSEL_OFS ||
			a == LVSI_STAT_OFS || a == LVSI_GATE_OFS;
	endfunction : hit

	lvsi_axil u_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.awaddr(awaddr),
		.awvalid(awvalid),
		.awready(awready),
		.wdata(wdata),
		.wstrb(wstrb),
		.wvalid(wvalid),
		.wready(wready),
		.bresp(bresp),
		.bvalid(bvalid),
		.bready(bready),
		.araddr(araddr),
		.arvalid(arvalid),
		.arready(arready),
		.rdata(rdata),
		.rresp(rresp),
		.rvalid(rvalid),
		.rready(rready),
		.wr_pulse(wr_pulse),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_hit(rd_hit),
		.wr_hit(wr_hit)
	);

	assign rd_hit = hit(rd_addr);
	assign wr_hit = hit(wr_addr);
	assign enter_req = wr_pulse && wr_addr == LVSI_CTRL_OFS && wr_strb[0]
		&& wr_data[CTRL_ENTER_BIT];

	// Control and clock select registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RESET;
			clksel_q <= CLKSEL_RESET;
		end else if (clk_en && wr_pulse && wr_strb[0]) begin
			if (wr_addr == LVSI_CTRL_OFS) begin
				ctrl_q[4:1] <= wr_data[4:1];
			end
			if (wr_addr == LVSI_CLKSEL_OFS) begin
				clksel_q <= wr_data[5:0];
			end
		end
	end

	// Sleep state machine; entry checks software ordering
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= LVSI_RUN;
			err_q <= ERR_NONE;
		end else if (clk_en) begin
			unique case (state_q)
				LVSI_RUN: begin
					if (enter_req) begin
						if (ctrl_q[CTRL_MAIN_OSC_BIT]) begin
							err_q <= ERR_MAIN_RUN;
						end else if (ctrl_q[CTRL_PLL_EN_BIT]) begin
							err_q <= ERR_PLL_ON;
						end else if (ctrl_q[CTRL_DAC_BIT]) begin
							err_q <= ERR_DAC_ON;
						end else begin
							err_q <= ERR_NONE;
							state_q <= LVSI_SLEEP;
						end
					end
				end
				LVSI_SLEEP: begin
					if (wake_req) begin
						state_q <= LVSI_WAKE;
					end
				end
				LVSI_WAKE: state_q <= LVSI_RUN;
			endcase
		end
	end

	// Pin holding at entry
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rto_q <= '0;
			port_q <= '0;
		end else if (clk_en && state_q != LVSI_SLEEP) begin
			rto_q <= rto_live;
			port_q <= port_live;
		end
	end

	// Unit gating in sleep
	always_comb begin
		gate_d = GATE_ALL;
		gate_d[G_PLL] = ctrl_q[CTRL_PLL_EN_BIT];
		gate_d[G_ADC] = ctrl_q[CTRL_ADC_BIT];
		gate_d[G_DAC] = ctrl_q[CTRL_DAC_BIT];
		if (state_q == LVSI_SLEEP) begin
			gate_d = '0;
			gate_d[G_LVD] = 1'b1;
			gate_d[G_KEY] = 1'b1;
			gate_d[G_INTC] = 1'b1;
			gate_d[G_TMM] =
				slow_src_ok(clksel_q[CLKSEL_TMM_POS +: 2]);
			gate_d[G_WDT] =
				slow_src_ok(clksel_q[CLKSEL_WDT_POS +: 2]);
			gate_d[G_WATCH] =
				clksel_q[CLKSEL_WATCH_POS +: 2] == SRC_SUBCLK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			unit_run <= '0;
		end else if (clk_en) begin
			unit_run <= gate_d;
		end
	end

	assign rto_pins = rto_q;
	assign port_pins = port_q;
	assign in_sleep = state_q == LVSI_SLEEP;
	assign cpu_regs_hold = in_sleep;

	always_comb begin
		rd_data = 32'h00000000;
		unique case (rd_addr)
			LVSI_CTRL_OFS: rd_data[4:0] = ctrl_q;
			LVSI_CLKSEL_OFS: rd_data[5:0] = clksel_q;
			LVSI_STAT_OFS: rd_data[3:0] = {in_sleep, state_q == LVSI_WAKE,
				err_q};
			LVSI_GATE_OFS: rd_data[GATE_W-1:0] = unit_run;
			default: rd_data = 32'h00000000;
		endcase
	end

	a_entry_needs_stop: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && state_q == LVSI_RUN && enter_req &&
		(ctrl_q[CTRL_MAIN_OSC_BIT] || ctrl_q[CTRL_PLL_EN_BIT] ||
		ctrl_q[CTRL_DAC_BIT])
		|=> state_q == LVSI_RUN)
		else $error("sleep entered with main clock or PLL on");
	a_watch_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && state_q == LVSI_SLEEP |=> !unit_run[G_CPU] &&
		unit_run[G_WATCH] == ($past(clksel_q[5:4]) == SRC_SUBCLK))
		else $error("watch timer gating wrong in sleep");
	a_rto_held: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && state_q == LVSI_SLEEP && $past(state_q) == LVSI_SLEEP
		|-> $stable(rto_pins) && $stable(port_pins))
		else $error("held pins changed in sleep");
	// Release request seen while asleep, then one enabled cycle
	sequence s_wake_seen;
		clk_en && state_q == LVSI_SLEEP && wake_req ##1 clk_en;
	endsequence
	// One waking cycle, then running again
	sequence s_wake_steps;
		state_q == LVSI_WAKE ##1 state_q == LVSI_RUN;
	endsequence
	a_wake_exit: assert property (@(posedge aclk) disable iff (!aresetn)
		s_wake_seen |-> s_wake_steps)
		else $error("wake request did not end sleep");
	a_sleep_units_off: assert property (@(posedge aclk)
		disable iff (!aresetn)
		clk_en && state_q == LVSI_SLEEP |=> !unit_run[G_PLL] &&
		!unit_run[G_DMA] && !unit_run[G_ADC] && !unit_run[G_DAC] &&
		!unit_run[G_CRC] && unit_run[G_LVD] && unit_run[G_KEY])
		else $error("unit gating wrong in sleep");
	a_intc_alive: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && state_q == LVSI_SLEEP |=> unit_run[G_INTC])
		else $error("interrupt controller gated in sleep");
	a_timer_m_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && state_q == LVSI_SLEEP |=> unit_run[G_TMM] ==
		($past(clksel_q[1:0]) == SRC_INTOSC_DIV8 ||
		$past(clksel_q[1:0]) == SRC_SUBCLK))
		else $error("timer M gating wrong in sleep");
	a_pins_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && state_q != LVSI_SLEEP |=> port_pins == $past(port_live)
		&& rto_pins == $past(rto_live))
		else $error("pins did not follow live values");
endmodule : lvsi_gating
`default_nettype wire

// *** verification/tb_lvsi_gating.sv ***
// Self-checking bench for the sub-idle gating block
`timescale 1ns/10ps
`default_nettype none
module tb_lvsi_gating;
	import lvsi_pkg::*;
	logic aclk, aresetn, clk_en, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, wake_req;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, s;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	logic [RTO_W-1:0] rto_live, rto_pins;
	logic [PORT_W-1:0] port_live, port_pins;
	logic [GATE_W-1:0] unit_run, ex, mask;
	logic cpu_regs_hold, in_sleep;
	logic [23:0] held;
	int error_cnt, n_tests, tm, wd, wa, n;
	// Each entry attempt is judged on the bits left by the write before
	int ctl_q[$] = '{32'h03, 32'h11, 32'h01};
	lvsi_gating u_lvsi_gating (.aclk(aclk), .aresetn(aresetn),
		.clk_en(clk_en), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.wake_req(wake_req), .rto_live(rto_live), .port_live(port_live),
		.rto_pins(rto_pins), .port_pins(port_pins), .unit_run(unit_run),
		.cpu_regs_hold(cpu_regs_hold), .in_sleep(in_sleep));
	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : tally_and_finish
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		logic [1:0] br;
		int k;
		@(posedge aclk);
		awaddr <= a; wdata <= d; wstrb <= 4'hF;
		awvalid <= 1; wvalid <= 1; bready <= 1;
		k = 0;
		do begin
			@(negedge aclk);
			ta = awvalid && awready === 1;
			tw = wvalid && wready === 1;
			tb = bready && bvalid === 1;
			br = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 0;
			if (tw) wvalid <= 0;
			if (tb) bready <= 0;
			k++;
		end while (!tb && k < 50);
		chk("write done", tb, 1);
		chk("write resp", br, (a[7:4] == 4'h0 && a[1:0] == 2'h0) ?
			AXI_OKAY : AXI_SLVERR);
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		int k;
		@(posedge aclk);
		araddr <= a; arvalid <= 1; rready <= 1;
		k = 0;
		do begin
			@(negedge aclk);
			ta = arvalid && arready === 1;
			tr = rready && rvalid === 1;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 0;
			if (tr) rready <= 0;
			k++;
		end while (!tr && k < 50);
		chk("read done", tr, 1);
	endtask : axr
	task automatic waitsl(input logic v);
		n = 0;
		while (in_sleep !== v && n < 20) begin
			@(negedge aclk);
			n++;
		end
		chk("sleep state", in_sleep, v);
		repeat (3) @(posedge aclk);
	endtask : waitsl
	initial begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		tally_and_finish;
	end
	initial begin
		aresetn = 0; clk_en = 1; awvalid = 0; wvalid = 0; bready = 0;
		arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
		wstrb = 0; wake_req = 0; rto_live = 0; port_live = 0;
		s = 32'd72049;
		mask = GATE_ALL;
		repeat (10) @(posedge aclk);
		aresetn <= 1;
		axr(LVSI_CTRL_OFS, rd, rs);
		chk("ctrl reset", rd, 32'h16);
		axr(8'h10, rd, rs);
		chk("unmapped resp", rs, AXI_SLVERR);
		chk("unmapped data", rd, 0);
		axw(8'h10, 32'hFFFFFFFF);
		axr(LVSI_CTRL_OFS, rd, rs);
		chk("ctrl kept", rd, {27'h0, CTRL_RESET});
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			axw(LVSI_CTRL_OFS, ctl_q[i]);
			repeat (3) @(posedge aclk);
			chk("refused entry", in_sleep, 0);
			axr(LVSI_STAT_OFS, rd, rs);
			chk("error code", rd[1:0], i + 1);
		end
		$display("test refusal done");
		for (int i = 0; i < 3; i++) begin
			tm = i; wd = (i + 1) % 3; wa = (i + 2) % 3;
			axw(LVSI_CLKSEL_OFS, tm | (wd << 2) | (wa << 4));
			axw(LVSI_CTRL_OFS, i < 2 ? 32'h08 : 32'h00);
			s = lfsr(s);
			{rto_live, port_live} <= s[23:0];
			held = s[23:0];
			axw(LVSI_CTRL_OFS, i < 2 ? 32'h09 : 32'h01);
			waitsl(1);
			ex = 0;
			ex[G_LVD] = 1;
			ex[G_KEY] = 1;
			ex[G_INTC] = 1;
			ex[G_TMM] = (tm == 1 || tm == 2);
			ex[G_WDT] = (wd == 1 || wd == 2);
			ex[G_WATCH] = (wa == 2);
			chk("sleep gates", unit_run & mask, ex);
			chk("regs hold", cpu_regs_hold, 1);
			axr(LVSI_GATE_OFS, rd, rs);
			chk("gate reg", rd & mask, ex);
			axr(LVSI_STAT_OFS, rd, rs);
			chk("asleep flag", rd[3], 1);
			s = lfsr(s);
			{rto_live, port_live} <= s[23:0];
			repeat (4) @(posedge aclk);
			chk("rto held", rto_pins, held[23:16]);
			chk("port held", port_pins, held[15:0]);
			if (i == 0) begin
				clk_en <= 0;
				wake_req <= 1;
				repeat (4) @(posedge aclk);
				chk("frozen sleep", in_sleep, 1);
				clk_en <= 1;
			end
			wake_req <= 1;
			waitsl(0);
			wake_req <= 0;
			chk("port follows", port_pins, s[15:0]);
			chk("cpu runs", unit_run[G_CPU], 1);
			chk("regs free", cpu_regs_hold, 0);
			$display("test sleep %0d done", i);
		end
		tally_and_finish;
	end
endmodule : tb_lvsi_gating
`default_nettype wire
